// *** buck_charger_gate_control.sv ***
// Purpose: Gate sequencing, protections and power-path selection
// Assumes: Comparator flags are asynchronous levels from the analog side
// Notes:   Switching period fixed at PERIOD_CYC clock cycles

`timescale 1ns/1ps
`default_nettype none

module buck_charger_gate_control #(
  parameter int unsigned STEP_CYCLES = charger_gate_pkg::STEP_CYC,
  parameter int unsigned GAP_CYCLES  = charger_gate_pkg::PATH_GAP_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  input  wire charger_gate_pkg::comp_s comp_i,
  input  wire logic [3:0]              addr_i,
  input  wire logic [31:0]             wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [31:0]             rdata_o,
  output logic                         high_gate_o,
  output logic                         low_gate_o,
  output logic                         adapter_path_switch_o,
  output logic                         battery_path_switch_o,
  output logic                         gate_drive_regulator_o,
  output logic                         discharge_sink_o,
  output logic                         timer_pause_o,
  output logic      [7:0]              iref_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  charger_gate_pkg::comp_s meta_q;
  charger_gate_pkg::comp_s cmp_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      cmp_q  <= '0;
    end else begin
      meta_q <= comp_i;
      cmp_q  <= meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  logic       charge_en_q;
  logic [7:0] iset_q;
  logic       rd_pend_q;
  logic [3:0] rd_addr_q;

  wire wr_ctrl = wr_i && (addr_i == charger_gate_pkg::REG_CTRL);
  wire wr_iset = wr_i && (addr_i == charger_gate_pkg::REG_ISET);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      charge_en_q <= 1'b0;
      iset_q      <= charger_gate_pkg::ISET_RST;
      rd_pend_q   <= 1'b0;
      rd_addr_q   <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        charge_en_q <= wdata_i[0];
      end
      if (wr_iset) begin
        iset_q <= wdata_i[7:0];
      end
      rd_pend_q <= rd_i;
      rd_addr_q <= addr_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Thermal hysteresis and charge qualification

  logic thermal_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      thermal_q <= 1'b0;
    end else if (cmp_q.thermal_hot) begin
      thermal_q <= 1'b1;
    end else if (cmp_q.thermal_cool) begin
      thermal_q <= 1'b0;
    end
  end

  charger_gate_pkg::path_e path_q;

  // Charging needs the adapter path settled; a trip drops it at once
  wire charging = charge_en_q && !cmp_q.supply_uv && !cmp_q.input_ov
                  && !thermal_q && (path_q == charger_gate_pkg::PATH_AC);

  assign discharge_sink_o = charging;
  assign timer_pause_o    = cmp_q.bat_ovp || thermal_q;
  assign gate_drive_regulator_o = !cmp_q.supply_uv;

  //////////////////////////////////////////////////////////////////////////////
  // Power-path selector with break-before-make gap

  logic [$clog2(GAP_CYCLES+1)-1:0] gap_cnt_q;

  wire want_ac  = cmp_q.adapter_present && !cmp_q.input_ov;
  wire gap_done = (gap_cnt_q == '0);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      path_q    <= charger_gate_pkg::PATH_BAT;
      gap_cnt_q <= '0;
    end else begin
      case (path_q)
        charger_gate_pkg::PATH_BAT: begin
          if (want_ac && !cmp_q.supply_uv) begin
            path_q    <= charger_gate_pkg::PATH_GAP;
            gap_cnt_q <= ($clog2(GAP_CYCLES+1))'(GAP_CYCLES - 1);
          end
        end
        charger_gate_pkg::PATH_GAP: begin
          // A request that flips mid-gap still waits the whole gap out
          if (gap_done) begin
            path_q <= want_ac ? charger_gate_pkg::PATH_AC : charger_gate_pkg::PATH_BAT;
          end else begin
            gap_cnt_q <= gap_cnt_q - 1'b1;
          end
        end
        charger_gate_pkg::PATH_AC: begin
          if (!want_ac || cmp_q.supply_uv) begin
            path_q    <= charger_gate_pkg::PATH_GAP;
            gap_cnt_q <= ($clog2(GAP_CYCLES+1))'(GAP_CYCLES - 1);
          end
        end
        default: path_q <= charger_gate_pkg::PATH_BAT;
      endcase
    end
  end

  // Both directions sit out the full gap with both switches off
  assign adapter_path_switch_o = !cmp_q.supply_uv && (path_q == charger_gate_pkg::PATH_AC);
  assign battery_path_switch_o = !cmp_q.supply_uv
                                 && (path_q == charger_gate_pkg::PATH_BAT);

  //////////////////////////////////////////////////////////////////////////////
  // Soft-start current reference

  logic                              charging_q;
  logic [3:0]                        step_q;
  logic [$clog2(STEP_CYCLES+1)-1:0] step_cnt_q;

  wire fast_entry = charging && !charging_q;
  wire step_tick  = (step_cnt_q == ($clog2(STEP_CYCLES+1))'(STEP_CYCLES - 1));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      charging_q <= 1'b0;
      step_q     <= 4'h0;
      step_cnt_q <= '0;
    end else begin
      charging_q <= charging;
      // The idle cycle before entry reloads step one, so entry starts counting
      if (!charging) begin
        step_q     <= 4'h1;
        step_cnt_q <= '0;
      end else if (step_q != 4'(charger_gate_pkg::RAMP_STEPS)) begin
        if (step_tick) begin
          step_cnt_q <= '0;
          step_q     <= step_q + 4'h1;
        end else begin
          step_cnt_q <= step_cnt_q + 1'b1;
        end
      end
    end
  end

  logic [11:0] iref_prod;
  assign iref_prod = iset_q * step_q;
  assign iref_o    = charging ? iref_prod[10:3] : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Switching period, bootstrap watch and mode

  logic [7:0] per_q;
  logic [1:0] boot_cnt_q;
  logic       boot_seen_q;

  wire cycle_start = (per_q == 8'(charger_gate_pkg::PERIOD_CYC - 1));
  wire sync_mode   = cmp_q.sense_above_5mv && !cmp_q.bat_below_2v
                     && !cmp_q.avg_below_1p25mv;
  wire hs_block    = cmp_q.bat_ovp || cmp_q.over_current || !charging;
  wire boot_force  = (boot_cnt_q == 2'(charger_gate_pkg::BOOT_LOW_CYCLES));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      per_q       <= 8'h00;
      boot_cnt_q  <= 2'h0;
      boot_seen_q <= 1'b0;
    end else begin
      per_q <= cycle_start ? 8'h00 : per_q + 8'h01;
      if (cmp_q.boot_low) begin
        boot_seen_q <= 1'b1;
      end
      if (cycle_start) begin
        boot_seen_q <= 1'b0;
        if (boot_force || !boot_seen_q) begin
          boot_cnt_q <= 2'h0;
        end else if (boot_seen_q) begin
          boot_cnt_q <= boot_cnt_q + 2'h1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Gate sequencer

  charger_gate_pkg::phase_e ph_q;
  logic [3:0] ph_cnt_q;
  logic       ls_done_q;
  logic       from_low_q;
  logic       hs_this_q;
  logic       duty_seen_q;

  wire hs_want    = cmp_q.pwm_req && !hs_block && !boot_force
                    && (per_q < 8'(charger_gate_pkg::MAX_ON_CYC));
  wire refresh_rq = cmp_q.boot_low && !ls_done_q;
  wire ls_want    = charging && !ls_done_q
                    && ((sync_mode && cmp_q.sense_above_5mv
                         && (duty_seen_q || hs_this_q)) || boot_force
                        || refresh_rq);
  wire dead_done  = (ph_cnt_q == 4'(charger_gate_pkg::DEAD_CYC - 1));
  wire pulse_done = !sync_mode && !boot_force
                    && (ph_cnt_q == 4'(charger_gate_pkg::REFRESH_CYC - 1));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_q      <= charger_gate_pkg::PH_IDLE;
      ph_cnt_q   <= 4'h0;
      ls_done_q  <= 1'b0;
      from_low_q <= 1'b0;
    end else begin
      ph_cnt_q <= ph_cnt_q + 4'h1;
      if (cycle_start) begin
        ls_done_q <= 1'b0;
      end
      case (ph_q)
        charger_gate_pkg::PH_IDLE: begin
          if (hs_want) begin
            ph_q <= charger_gate_pkg::PH_HIGH;
          end else if (ls_want) begin
            ph_q     <= charger_gate_pkg::PH_LOW;
            ph_cnt_q <= 4'h0;
          end
        end
        charger_gate_pkg::PH_HIGH: begin
          if (!hs_want) begin
            ph_q       <= charger_gate_pkg::PH_DEAD;
            ph_cnt_q   <= 4'h0;
            from_low_q <= 1'b0;
          end
        end
        charger_gate_pkg::PH_DEAD: begin
          // Hand over to the other switch first, so neither side starves
          if (dead_done) begin
            if (hs_want && (from_low_q || !ls_want)) begin
              ph_q <= charger_gate_pkg::PH_HIGH;
            end else if (ls_want) begin
              ph_q <= charger_gate_pkg::PH_LOW;
            end else begin
              ph_q <= charger_gate_pkg::PH_IDLE;
            end
            ph_cnt_q <= 4'h0;
          end
        end
        charger_gate_pkg::PH_LOW: begin
          // Leaving low-side always passes dead time before high-side;
          // a refresh pulse runs its full width even under a duty request
          if (!ls_want || pulse_done || (hs_want && sync_mode) || cycle_start) begin
            ph_q       <= charger_gate_pkg::PH_DEAD;
            ph_cnt_q   <= 4'h0;
            from_low_q <= 1'b1;
            if (!sync_mode || !cmp_q.sense_above_5mv) begin
              ls_done_q <= 1'b1;
            end
          end
        end
        default: ph_q <= charger_gate_pkg::PH_IDLE;
      endcase
    end
  end

  assign high_gate_o = (ph_q == charger_gate_pkg::PH_HIGH) && !hs_block;
  assign low_gate_o  = (ph_q == charger_gate_pkg::PH_LOW) && charging;

  // A whole period without high-side drive withdraws synchronous low-side drive
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hs_this_q   <= 1'b0;
      duty_seen_q <= 1'b0;
    end else if (cycle_start) begin
      hs_this_q   <= 1'b0;
      duty_seen_q <= hs_this_q || high_gate_o;
    end else if (high_gate_o) begin
      hs_this_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data

  wire [31:0] status_word = {24'h0, 1'b0, thermal_q, sync_mode, charging,
                             boot_force, path_q, cmp_q.bat_ovp};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= charger_gate_pkg::RD_ZERO;
    end else if (rd_i) begin
      case (addr_i)
        charger_gate_pkg::REG_CTRL:   rdata_o <= {31'h0, charge_en_q};
        charger_gate_pkg::REG_ISET:   rdata_o <= {24'h0, iset_q};
        charger_gate_pkg::REG_STATUS: rdata_o <= status_word;
        charger_gate_pkg::REG_IREF:   rdata_o <= {24'h0, iref_o};
        default:                      rdata_o <= charger_gate_pkg::RD_ZERO;
      endcase
    end else begin
      rdata_o <= charger_gate_pkg::RD_ZERO;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  never_both_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(high_gate_o && low_gate_o)) else $error("both gates on");
  dead_gap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(high_gate_o) |-> !low_gate_o [*3]) else $error("dead time short");
  ovp_block_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cmp_q.bat_ovp |-> !high_gate_o) else $error("high on in overvoltage");
  ocp_block_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cmp_q.over_current |-> !high_gate_o) else $error("high on in overcurrent");
  uv_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cmp_q.supply_uv |-> !adapter_path_switch_o && !battery_path_switch_o
    && !low_gate_o) else $error("active in undervoltage");
  path_bbm_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(battery_path_switch_o) |-> !adapter_path_switch_o [*8])
    else $error("path overlap");
  path_back_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(adapter_path_switch_o) |-> !battery_path_switch_o [*8])
    else $error("path overlap back");
  sink_chg_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    discharge_sink_o == charging) else $error("sink outside charge");
  pause_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (thermal_q || cmp_q.bat_ovp) |-> timer_pause_o) else $error("timer not paused");
  ramp_rst_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fast_entry |=> step_q == 4'h1) else $error("ramp not restarted");
  ovin_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cmp_q.input_ov |-> !charging ##1 !adapter_path_switch_o)
    else $error("charge in input overvoltage");

  hs_cov: cover property (@(posedge clk_i) $rose(high_gate_o));
  ls_cov: cover property (@(posedge clk_i) $fell(high_gate_o) ##[1:10] low_gate_o);
  boot_cov: cover property (@(posedge clk_i) boot_force);
  ac_cov: cover property (@(posedge clk_i) $rose(adapter_path_switch_o));

endmodule

`default_nettype wire

// *** buck_charger_gate_control_tb.sv ***
// Purpose: Self-checking bench for the charger gate control
// Assumes: Short soft-start step and path gap parameters
// Notes:   Comparator flags pass two sync flops, so waits allow slack
`timescale 1ns/1ps
`default_nettype none
module buck_charger_gate_control_tb;
  localparam int unsigned STEP = 20;
  localparam int unsigned GAP  = 8;
  logic                    clk_i   = 1'b0;
  logic                    nrst_i  = 1'b0;
  logic                    wr_i    = 1'b0;
  logic                    rd_i    = 1'b0;
  logic                    clr     = 1'b1;
  logic [3:0]              addr_i  = 4'h0;
  logic [31:0]             wdata_i = 32'h0;
  charger_gate_pkg::comp_s comp_i  = '0;
  logic [31:0]             rdata_o;
  logic [31:0]             rv;
  logic                    high_gate_o;
  logic                    low_gate_o;
  logic                    adapter_path_switch_o;
  logic                    battery_path_switch_o;
  logic                    gate_drive_regulator_o;
  logic                    discharge_sink_o;
  logic                    timer_pause_o;
  logic [7:0]              iref_o;
  logic                    ovl;
  logic [15:0]             hmax;
  logic [15:0]             lmax;
  logic [15:0]             gmin;
  logic [15:0]             hsum;
  int                      fail_count  = 0;
  int                      check_count = 0;

  always #5 clk_i = ~clk_i;

  buck_charger_gate_control #(.STEP_CYCLES(STEP), .GAP_CYCLES(GAP)) uut (
    .clk_i(clk_i), .nrst_i(nrst_i), .comp_i(comp_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .high_gate_o(high_gate_o), .low_gate_o(low_gate_o),
    .adapter_path_switch_o(adapter_path_switch_o),
    .battery_path_switch_o(battery_path_switch_o),
    .gate_drive_regulator_o(gate_drive_regulator_o),
    .discharge_sink_o(discharge_sink_o), .timer_pause_o(timer_pause_o),
    .iref_o(iref_o));

  gate_driver_model drv (
    .clk_i(clk_i), .clear_i(clr), .high_cmd_i(high_gate_o),
    .low_cmd_i(low_gate_o), .overlap_o(ovl), .high_max_o(hmax),
    .low_max_o(lmax), .gap_min_o(gmin), .high_sum_o(hsum));

  ////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic cbit(input logic got, input logic exp, input string m);
    cmp({31'h0, got}, {31'h0, exp}, m);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 v = rdata_o;
  endtask
  // Clears the driver model, lets n cycles of switching pass
  task automatic watch(input int n);
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    cyc(n);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(charger_gate_pkg::REG_CTRL, rv);
    cmp(rv, 32'h0, "ctrl reset");
    rd(charger_gate_pkg::REG_ISET, rv);
    cmp(rv, {24'h0, charger_gate_pkg::ISET_RST}, "iset reset");
    wr(4'h9, 32'hffff_ffff);
    rd(4'h9, rv);
    cmp(rv, 32'h0, "unmapped read");
    cmp({24'h0, iref_o}, 32'h0, "iref idle");
    cbit(battery_path_switch_o, 1'b1, "battery path default");
    cbit(gate_drive_regulator_o, 1'b1, "regulator on");
    $display("test reset done");
  endtask

  task automatic t_path_and_ramp;
    int n;
    logic [7:0] prev;
    @(posedge clk_i);
    comp_i.adapter_present <= 1'b1;
    for (n = 0; n < 20 && battery_path_switch_o; n++) begin
      @(posedge clk_i);
      #1;
    end
    for (n = 0; n < 40 && !adapter_path_switch_o; n++) begin
      @(posedge clk_i);
      #1;
    end
    cbit(n >= GAP && n <= GAP + 2, 1'b1, "path gap length");
    rd(charger_gate_pkg::REG_STATUS, rv);
    cmp({30'h0, rv[2:1]}, 32'h2, "adapter path status");
    wr(charger_gate_pkg::REG_ISET, 32'hf0);
    wr(charger_gate_pkg::REG_CTRL, 32'h1);
    #1 prev = 8'h00;
    for (int k = 1; k <= 8; k++) begin
      n = 0;
      while (iref_o === prev && n < 3 * STEP) begin
        @(posedge clk_i);
        #1 n++;
      end
      prev = iref_o;
      cmp({24'h0, iref_o}, 32'd30 * k, "ramp level");
      if (k > 1) cmp(n, STEP, "ramp step time");
    end
    cbit(discharge_sink_o, 1'b1, "sink while charging");
    $display("test path and ramp done");
  endtask

  task automatic mode_chk(input logic b2, input logic a1, input logic s5, input logic e);
    @(posedge clk_i);
    comp_i.bat_below_2v     <= b2;
    comp_i.avg_below_1p25mv <= a1;
    comp_i.sense_above_5mv  <= s5;
    cyc(340);
    rd(charger_gate_pkg::REG_STATUS, rv);
    cbit(rv[5], e, "sync mode select");
  endtask

  task automatic t_switching;
    comp_i.pwm_req <= 1'b1;
    mode_chk(1'b0, 1'b0, 1'b1, 1'b1);
    watch(500);
    cbit(ovl, 1'b0, "no overlap sync");
    cmp({16'h0, gmin}, charger_gate_pkg::DEAD_CYC, "dead time");
    cbit(hmax <= 16'(charger_gate_pkg::MAX_ON_CYC), 1'b1, "duty cap");
    cbit(hmax > 16'h0 && lmax > 16'h0, 1'b1, "both switch");
    mode_chk(1'b1, 1'b0, 1'b1, 1'b0);
    mode_chk(1'b0, 1'b1, 1'b1, 1'b0);
    mode_chk(1'b0, 1'b0, 1'b0, 1'b0);
    comp_i.boot_low <= 1'b1;
    watch(300);
    cmp({16'h0, lmax}, charger_gate_pkg::REFRESH_CYC, "refresh pulse");
    cbit(ovl, 1'b0, "no overlap dcm");
    comp_i.sense_above_5mv <= 1'b1;
    watch(5 * 166);
    rd(charger_gate_pkg::REG_STATUS, rv);
    for (int n = 0; n < 400 && !rv[3]; n++) rd(charger_gate_pkg::REG_STATUS, rv);
    cbit(rv[3], 1'b1, "bootstrap force");
    cbit(lmax >= 16'd160, 1'b1, "forced low run");
    comp_i.boot_low <= 1'b0;
    cyc(500);
    watch(340);
    cbit(hsum > 16'h0, 1'b1, "high resumes");
    @(posedge clk_i);
    comp_i.pwm_req <= 1'b0;
    cyc(340);
    watch(340);
    cmp({16'h0, hsum}, 32'h0, "zero duty high");
    cmp({16'h0, lmax}, 32'h0, "zero duty low");
    $display("test switching done");
  endtask

  task automatic t_protect;
    comp_i.pwm_req <= 1'b1;
    comp_i.bat_ovp <= 1'b1;
    watch(340);
    cmp({16'h0, hsum}, 32'h0, "ovp high off");
    cbit(timer_pause_o, 1'b1, "ovp timer pause");
    comp_i.bat_ovp      <= 1'b0;
    comp_i.over_current <= 1'b1;
    watch(340);
    cmp({16'h0, hsum}, 32'h0, "oc high off");
    comp_i.over_current <= 1'b0;
    watch(340);
    cbit(hsum > 16'h0, 1'b1, "oc resume");
    comp_i.thermal_hot <= 1'b1;
    cyc(6);
    cbit(discharge_sink_o, 1'b0, "thermal stop");
    cbit(timer_pause_o, 1'b1, "thermal pause");
    comp_i.thermal_hot <= 1'b0;
    cyc(40);
    cmp({24'h0, iref_o}, 32'h0, "thermal hold");
    comp_i.thermal_cool <= 1'b1;
    for (int n = 0; n < 60 && iref_o === 8'h0; n++) @(posedge clk_i);
    #1 cmp({24'h0, iref_o}, 32'd30, "ramp restart");
    $display("test protect done");
  endtask

  task automatic t_supply;
    comp_i.input_ov <= 1'b1;
    cyc(6);
    cbit(discharge_sink_o, 1'b0, "ov stops charge");
    for (int n = 0; n < 40 && !battery_path_switch_o; n++) @(posedge clk_i);
    cbit(adapter_path_switch_o, 1'b0, "ov adapter off");
    cbit(battery_path_switch_o, 1'b1, "ov battery on");
    comp_i.supply_uv <= 1'b1;
    cyc(6);
    cbit(gate_drive_regulator_o, 1'b0, "uv bias off");
    cbit(battery_path_switch_o | adapter_path_switch_o, 1'b0, "uv paths off");
    cbit(high_gate_o | low_gate_o, 1'b0, "uv gates off");
    $display("test supply done");
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    nrst_i <= 1'b1;
    t_reset();
    t_path_and_ramp();
    t_switching();
    t_protect();
    t_supply();
    stop_test();
  end

  // Tests take about 6000 cycles
  initial begin
    cyc(30000);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire

// *** charger_gate_pkg.sv ***
// Purpose: Shared constants and types for the buck charger gate control
// Assumes: 100 MHz core clock
// Notes:   Register map is a plain strobe port with one-cycle read latency

package charger_gate_pkg;

  localparam int unsigned CLK_MHZ = 100;

  // Timing figures in their own units, and derived cycle counts
  localparam int unsigned DEAD_NS         = 30;
  localparam int unsigned DEAD_CYC        = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned REFRESH_NS      = 80;
  localparam int unsigned REFRESH_CYC     = (REFRESH_NS * CLK_MHZ) / 1000;
  localparam int unsigned STEP_US         = 1600;
  localparam int unsigned STEP_CYC        = STEP_US * CLK_MHZ;
  localparam int unsigned PATH_GAP_US     = 10;
  localparam int unsigned PATH_GAP_CYC    = (PATH_GAP_US * CLK_MHZ + 0) / 1;
  localparam int unsigned PERIOD_CYC      = 166;
  localparam int unsigned MAX_DUTY_PERMIL = 995;
  localparam int unsigned MAX_ON_CYC      = (PERIOD_CYC * MAX_DUTY_PERMIL) / 1000;
  localparam int unsigned BOOT_LOW_CYCLES = 3;
  localparam int unsigned RAMP_STEPS      = 8;

  // Register indices
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ISET   = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_IREF   = 4'h3;

  localparam logic [7:0]  ISET_RST = 8'h80;
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

  typedef enum logic [1:0] {
    PATH_BAT  = 2'b00,
    PATH_GAP  = 2'b01,
    PATH_AC   = 2'b10
  } path_e;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_HIGH = 2'b01,
    PH_DEAD = 2'b10,
    PH_LOW  = 2'b11
  } phase_e;

  // Comparator flags from the analog front end
  typedef struct packed {
    logic pwm_req;          // Loop comparator: error amp above ramp
    logic boot_low;         // Bootstrap supply below 4.2 V
    logic sense_above_5mv;  // Charge sense above 5 mV
    logic avg_below_1p25mv; // Averaged sense below 1.25 mV
    logic bat_below_2v;
    logic bat_ovp;          // Battery at or above 102 %
    logic over_current;     // Above 160 % of programmed
    logic input_ov;
    logic supply_uv;
    logic thermal_hot;      // Above 145 C
    logic thermal_cool;     // Below 130 C
    logic adapter_present;
  } comp_s;

endpackage

// *** gate_driver_model.sv ***
// Purpose: Stand-in for the two power switch gate drivers
// Assumes: Gate commands are levels that settle within one core clock
// Notes:   Measures run lengths and dead gaps so the bench can judge them
`timescale 1ns/1ps
`default_nettype none
module gate_driver_model (
  input  wire logic        clk_i,
  input  wire logic        clear_i,
  input  wire logic        high_cmd_i,
  input  wire logic        low_cmd_i,
  output logic             overlap_o,
  output logic [15:0]      high_max_o,
  output logic [15:0]      low_max_o,
  output logic [15:0]      gap_min_o,
  output logic [15:0]      high_sum_o
);
  logic [15:0] hrun;
  logic [15:0] lrun;
  logic [15:0] gap;
  logic        last_high;
  always @(posedge clk_i) begin
    if (clear_i) begin
      overlap_o  <= 1'b0;
      high_max_o <= 16'h0;
      low_max_o  <= 16'h0;
      gap_min_o  <= 16'hffff;
      high_sum_o <= 16'h0;
      hrun       <= 16'h0;
      lrun       <= 16'h0;
      gap        <= 16'hffff;
      last_high  <= 1'b0;
    end else begin
      // Both switches on would short the input rail
      if (high_cmd_i && low_cmd_i) overlap_o <= 1'b1;
      hrun <= high_cmd_i ? hrun + 16'h1 : 16'h0;
      lrun <= low_cmd_i ? lrun + 16'h1 : 16'h0;
      if (high_cmd_i && hrun + 16'h1 > high_max_o) high_max_o <= hrun + 16'h1;
      if (low_cmd_i && lrun + 16'h1 > low_max_o) low_max_o <= lrun + 16'h1;
      high_sum_o <= high_sum_o + {15'h0, high_cmd_i};
      if (high_cmd_i || low_cmd_i) begin
        gap       <= 16'h0;
        last_high <= high_cmd_i;
      end else if (gap != 16'hffff) begin
        gap <= gap + 16'h1;
      end
      // Only a hand-over from one switch to the other counts as dead time
      if (((high_cmd_i && hrun == 16'h0 && !last_high) ||
           (low_cmd_i && lrun == 16'h0 && last_high)) && gap < gap_min_o) begin
        gap_min_o <= gap;
      end
    end
  end
endmodule
`default_nettype wire
